/* File: pwm_unit_pkg.sv */
// Shared constants, types and helper functions of the fine and coarse PWM unit.
package pwm_unit_pkg;

   // Step time: one resolution step of the wide channel.
   localparam int CLK_PERIOD_NS      = 50;
   localparam int STEP_TIME_NS       = 500;
   localparam int STEP_CYCLES        = (STEP_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   // Narrow channel segment time and its length in steps.
   localparam int NARROW_SEG_TIME_NS = 16000;
   localparam int NARROW_SEG_STEPS   = NARROW_SEG_TIME_NS / STEP_TIME_NS;

   localparam int NARROW_CHANNELS = 8;
   localparam int FINE_W          = 6;
   localparam int COARSE_W        = 8;
   localparam int WIDE_W          = COARSE_W + FINE_W;
   localparam int ADDR_W          = 8;
   localparam int PINS            = NARROW_CHANNELS + 1;

   // Register byte offsets on the bus.
   localparam logic [ADDR_W-1:0] OFS_WIDE_HIGH   = 8'h00;
   localparam logic [ADDR_W-1:0] OFS_WIDE_LOW    = 8'h04;
   localparam logic [ADDR_W-1:0] OFS_NARROW_BASE = 8'h08;
   localparam logic [ADDR_W-1:0] OFS_NARROW_LAST = 8'h24;
   localparam logic [ADDR_W-1:0] OFS_OUT_CTRL1   = 8'h28;
   localparam logic [ADDR_W-1:0] OFS_OUT_CTRL2   = 8'h2C;
   localparam logic [ADDR_W-1:0] OFS_STATUS      = 8'h30;

   // Output select field positions: control 1 bits 1..7, control 2 bits 0..1.
   localparam int CTRL1_SEL_LSB = 1;
   localparam int CTRL2_SEL_LSB = 0;
   localparam int STATUS_SEG_LSB = 8;

   localparam logic [7:0]       OUT_CTRL_RESET = 8'h00;
   localparam logic [FINE_W-1:0] DATA_RESET    = 6'h00;

   typedef struct packed {
      logic        step_en;
      logic [7:0]  fine;
      logic [5:0]  slot;
      logic [5:0]  seg;
      logic        narrow_start;
   } timebase_t;

   // Latch bit that owns a slot or segment: the lowest set bit at position p maps to
   // bit 5-p, so bit 5 owns 32 indices, bit 0 owns index 32, and index 0 has no owner.
   function automatic logic [2:0] weight_bit(input logic [5:0] idx);
      logic [2:0] r;
      r = 3'h0;
      for (int p = 5; p >= 0; p--) begin
         if (idx[p]) begin
            r = 3'(5 - p);
         end
      end
      return r;
   endfunction

   function automatic logic slot_enabled(input logic [5:0] idx, input logic [5:0] pattern);
      return (idx != 6'h00) && pattern[weight_bit(idx)];
   endfunction

endpackage

/* File: step_timer.sv */
// Step enable divider and the shared step position counter.
`timescale 1ns/1ps
module step_timer #(
   parameter int STEP_DIV = pwm_unit_pkg::STEP_CYCLES
) (
   input  wire logic                   ref_clk,
   input  wire logic                   rst,
   output      pwm_unit_pkg::timebase_t tb
);
   import pwm_unit_pkg::*;

   typedef struct packed {
      logic [7:0]        div;
      logic [WIDE_W-1:0] count;
      logic              step_en;
   } timer_state_t;

   timer_state_t s_reg;
   timer_state_t s_next;

   always_comb begin
      s_next = s_reg;
      s_next.step_en = (s_reg.div == 8'(STEP_DIV - 1));
      s_next.div = s_next.step_en ? 8'h00 : s_reg.div + 8'h01;
      if (s_reg.step_en) begin
         s_next.count = s_reg.count + 14'h0001;
      end
   end

   always_ff @(posedge ref_clk) begin
      if (rst) begin
         s_reg <= '0;
      end else begin
         s_reg <= s_next;
      end
   end

   // Segment is 32 steps, so the narrow period is the low 11 bits of the count.
   assign tb.step_en      = s_reg.step_en;
   assign tb.fine         = s_reg.count[7:0];
   assign tb.slot         = s_reg.count[13:8];
   assign tb.seg          = s_reg.count[10:5];
   assign tb.narrow_start = s_reg.step_en && (s_reg.count[10:0] == 11'h7FF);

   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (rst);

   step_spacing_a: assert property (s_reg.step_en |-> ##10 s_reg.step_en)
      else $error("Step enable not spaced by the step divider.");
   step_single_a: assert property (s_reg.step_en |=> !s_reg.step_en)
      else $error("Step enable lasted more than one cycle.");
endmodule

/* File: narrow_pwm_channel.sv */
// One 6-bit channel: 64 segments, latch bits select binary-weighted pulse trains.
`timescale 1ns/1ps
module narrow_pwm_channel (
   input  wire logic                           ref_clk,
   input  wire logic                           rst,
   input  wire logic [5:0]                     seg,
   input  wire logic [pwm_unit_pkg::FINE_W-1:0] latch,
   output      logic                           level
);
   import pwm_unit_pkg::*;

   typedef struct packed {
      logic level;
   } narrow_state_t;

   narrow_state_t s_reg;
   narrow_state_t s_next;

   // Segment 0 has no owning bit, so 63/64 is the longest high time.
   always_comb begin
      s_next = s_reg;
      s_next.level = slot_enabled(seg, latch);
   end

   always_ff @(posedge ref_clk) begin
      if (rst) begin
         s_reg <= '0;
      end else begin
         s_reg <= s_next;
      end
   end

   assign level = s_reg.level;

   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (rst);

   never_full_a: assert property ((seg == 6'h00) |=> !level)
      else $error("Narrow channel high in segment zero.");
   weight_train_a: assert property ((seg != 6'h00) |=>
      (level == $past(latch[weight_bit(seg)])))
      else $error("Narrow channel level does not follow its owning latch bit.");
endmodule

/* File: pwm_unit.sv */
// Top of the PWM unit: bus slave, data registers, latches, wide modulator and pins.
`timescale 1ns/1ps
module pwm_unit (
   input  wire logic                         ref_clk,
   input  wire logic                         rst,
   input  wire logic                         wb_cyc_i,
   input  wire logic                         wb_stb_i,
   input  wire logic                         wb_we_i,
   input  wire logic [pwm_unit_pkg::ADDR_W-1:0] wb_adr_i,
   input  wire logic [3:0]                   wb_sel_i,
   input  wire logic [31:0]                  wb_dat_i,
   output      logic [31:0]                  wb_dat_o,
   output      logic                         wb_ack_o,
   output      logic [pwm_unit_pkg::PINS-1:0] pwm_out,
   output      logic [pwm_unit_pkg::PINS-1:0] pwm_oe_n
);
   import pwm_unit_pkg::*;

   typedef struct packed {
      logic                                    ack;
      logic [31:0]                             dat;
      logic [COARSE_W-1:0]                     wide_pwm_high_byte;
      logic [FINE_W-1:0]                       wide_pwm_low_bits;
      logic [WIDE_W-1:0]                       wide_latch;
      logic [NARROW_CHANNELS-1:0][FINE_W-1:0]  narrow_data;
      logic [NARROW_CHANNELS-1:0][FINE_W-1:0]  narrow_latch;
      logic [NARROW_CHANNELS-1:0]              narrow_pend;
      logic [7:0]                              ctrl1;
      logic [7:0]                              ctrl2;
      logic                                    wide_level;
      logic [PINS-1:0]                         pins;
      logic [PINS-1:0]                         oe_n;
   } unit_state_t;

   unit_state_t               s_reg;
   unit_state_t               s_next;
   timebase_t                 tb;
   logic [NARROW_CHANNELS-1:0] narrow_level;
   logic                      bus_req;
   logic                      bus_write;
   logic [COARSE_W-1:0]       coarse_width_field;
   logic [FINE_W-1:0]         fine_field;
   logic [PINS-1:0]           out_select;

   step_timer u_timer (
      .ref_clk (ref_clk),
      .rst     (rst),
      .tb      (tb)
   );

   for (genvar i = 0; i < NARROW_CHANNELS; i++) begin : g_narrow
      narrow_pwm_channel u_chan (
         .ref_clk (ref_clk),
         .rst     (rst),
         .seg     (tb.seg),
         .latch   (s_reg.narrow_latch[i]),
         .level   (narrow_level[i])
      );
   end

   function automatic logic narrow_hit(input logic [ADDR_W-1:0] adr);
      return (adr >= OFS_NARROW_BASE) && (adr <= OFS_NARROW_LAST) && (adr[1:0] == 2'h0);
   endfunction

   function automatic logic [2:0] narrow_index(input logic [ADDR_W-1:0] adr);
      logic [ADDR_W-1:0] d;
      d = adr - OFS_NARROW_BASE;
      return d[4:2];
   endfunction

   assign bus_req   = wb_cyc_i && wb_stb_i;
   // Writes land at the edge where the master sees ack, while its request still stands.
   assign bus_write = bus_req && s_reg.ack && wb_we_i && wb_sel_i[0];
   assign coarse_width_field = s_reg.wide_latch[WIDE_W-1:FINE_W];
   assign fine_field         = s_reg.wide_latch[FINE_W-1:0];
   assign out_select = {s_reg.ctrl2[CTRL2_SEL_LSB+1:CTRL2_SEL_LSB],
                        s_reg.ctrl1[7:CTRL1_SEL_LSB]};

   always_comb begin
      logic [8:0] high_steps;
      logic       stretch;
      high_steps = 9'h000;
      stretch    = 1'b0;
      s_next = s_reg;

      // Ack rises one cycle after the request and drops the cycle after.
      s_next.ack = bus_req && !s_reg.ack;
      s_next.dat = 32'h0000_0000;
      if (bus_req && !s_reg.ack && !wb_we_i) begin
         if (wb_adr_i == OFS_WIDE_HIGH) begin
            s_next.dat[COARSE_W-1:0] = s_reg.wide_pwm_high_byte;
         end else if (wb_adr_i == OFS_WIDE_LOW) begin
            s_next.dat[FINE_W-1:0] = s_reg.wide_pwm_low_bits;
         end else if (narrow_hit(wb_adr_i)) begin
            s_next.dat[FINE_W-1:0] = s_reg.narrow_data[narrow_index(wb_adr_i)];
         end else if (wb_adr_i == OFS_OUT_CTRL1) begin
            s_next.dat[7:0] = s_reg.ctrl1;
         end else if (wb_adr_i == OFS_OUT_CTRL2) begin
            s_next.dat[7:0] = s_reg.ctrl2;
         end else if (wb_adr_i == OFS_STATUS) begin
            s_next.dat[5:0] = tb.slot;
            s_next.dat[STATUS_SEG_LSB+5:STATUS_SEG_LSB] = tb.seg;
         end
      end

      // Narrow latches change only at a period boundary so no period is torn.
      for (int i = 0; i < NARROW_CHANNELS; i++) begin
         if (tb.narrow_start && s_reg.narrow_pend[i]) begin
            s_next.narrow_latch[i] = s_reg.narrow_data[i];
            s_next.narrow_pend[i]  = 1'b0;
         end
      end

      if (bus_write) begin
         if (wb_adr_i == OFS_WIDE_HIGH) begin
            s_next.wide_pwm_high_byte = wb_dat_i[COARSE_W-1:0];
         end else if (wb_adr_i == OFS_WIDE_LOW) begin
            s_next.wide_pwm_low_bits = wb_dat_i[FINE_W-1:0];
            // The high byte is taken as held; software must have written it first.
            s_next.wide_latch = {s_reg.wide_pwm_high_byte, wb_dat_i[FINE_W-1:0]};
         end else if (narrow_hit(wb_adr_i)) begin
            // A pending set wins over a transfer in the same cycle.
            s_next.narrow_data[narrow_index(wb_adr_i)] = wb_dat_i[FINE_W-1:0];
            s_next.narrow_pend[narrow_index(wb_adr_i)] = 1'b1;
         end else if (wb_adr_i == OFS_OUT_CTRL1) begin
            s_next.ctrl1 = wb_dat_i[7:0];
         end else if (wb_adr_i == OFS_OUT_CTRL2) begin
            s_next.ctrl2 = wb_dat_i[7:0];
         end
      end

      // Wide channel: coarse width per 256-step slot, plus one step in owned slots.
      stretch    = slot_enabled(tb.slot, fine_field);
      high_steps = {1'b0, coarse_width_field} + {8'h00, stretch};
      s_next.wide_level = ({1'b0, tb.fine} < high_steps);

      s_next.pins = {narrow_level, s_reg.wide_level};
      s_next.oe_n = ~out_select;
   end

   always_ff @(posedge ref_clk) begin
      if (rst) begin
         s_reg <= '0;
         s_reg.ctrl1 <= OUT_CTRL_RESET;
         s_reg.ctrl2 <= OUT_CTRL_RESET;
         s_reg.wide_pwm_high_byte <= {2'b00, DATA_RESET};
         s_reg.oe_n <= '1;
      end else begin
         s_reg <= s_next;
      end
   end

   assign wb_ack_o = s_reg.ack;
   assign wb_dat_o = s_reg.dat;
   assign pwm_out  = s_reg.pins;
   assign pwm_oe_n = s_reg.oe_n;

   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (rst);

   sequence low_write_s;
      bus_write && (wb_adr_i == OFS_WIDE_LOW);
   endsequence

   sequence narrow_move_s;
      tb.narrow_start && s_reg.narrow_pend[0];
   endsequence

   wide_load_a: assert property (low_write_s |=>
      (s_reg.wide_latch == {$past(s_reg.wide_pwm_high_byte), $past(wb_dat_i[FINE_W-1:0])}))
      else $error("Wide latch not loaded from high byte and written low bits.");
   narrow_move_a: assert property (narrow_move_s |=>
      (s_reg.narrow_latch[0] == $past(s_reg.narrow_data[0])))
      else $error("Narrow latch not updated at the period boundary.");
   coarse_high_a: assert property ((tb.fine < coarse_width_field) |=> s_reg.wide_level)
      else $error("Wide output low inside its coarse width.");
   slot_mid_a: assert property ((tb.fine == coarse_width_field && tb.slot == 6'h20 &&
      fine_field[0]) |=> s_reg.wide_level)
      else $error("Slot 32 not stretched by low bit 0.");
   slot_half_a: assert property ((tb.fine == coarse_width_field &&
      tb.slot[4:0] == 5'h10 && fine_field[1]) |=> s_reg.wide_level)
      else $error("Slot 16 mod 32 not stretched by low bit 1.");
   slot_sixteenth_a: assert property ((tb.fine == coarse_width_field &&
      tb.slot[3:0] == 4'h8 && fine_field[2]) |=> s_reg.wide_level)
      else $error("Slot 8 mod 16 not stretched by low bit 2.");
   coarse_end_a: assert property ((tb.fine > coarse_width_field) |=>
      !s_reg.wide_level)
      else $error("Wide output high past its stretched width.");
   slot_eighth_a: assert property ((tb.fine == coarse_width_field &&
      tb.slot[2:0] == 3'h4 && fine_field[3]) |=> s_reg.wide_level)
      else $error("Slot 4 mod 8 not stretched by low bit 3.");
   slot_quarter_a: assert property ((tb.fine == coarse_width_field &&
      tb.slot[1:0] == 2'h2 && fine_field[4]) |=> s_reg.wide_level)
      else $error("Slot 2 mod 4 not stretched by low bit 4.");
   slot_odd_a: assert property ((tb.fine == coarse_width_field && tb.slot[0] &&
      fine_field[5]) |=> s_reg.wide_level)
      else $error("Odd slot not stretched by low bit 5.");
   no_stretch_a: assert property ((tb.fine == coarse_width_field &&
      fine_field == 6'h00) |=> !s_reg.wide_level)
      else $error("Slot stretched with an all-zero low field.");
   pins_float_a: assert property ($past(rst) |-> (&pwm_oe_n))
      else $error("Shared port driven right after reset.");
   pin_select_a: assert property (!s_reg.ctrl1[CTRL1_SEL_LSB] |=> pwm_oe_n[0])
      else $error("Wide pin driven while not selected.");
endmodule

/* File: pwm_unit_tb.sv */
// Self-checking testbench of the fine and coarse PWM unit.
`timescale 1ns/1ps
`define CHK(nm, ex, got) begin checked++; if ((got) !== (ex)) begin n_mismatch++; \
   $display("wrong value %s expected %0h seen %0h", nm, ex, got); end end
module pwm_unit_tb;
   import pwm_unit_pkg::*;

   typedef struct packed {
      logic [7:0] hi;
      logic [5:0] lo;
   } row_t;

   logic                ref_clk;
   logic                rst;
   logic                wb_cyc_i;
   logic                wb_stb_i;
   logic                wb_we_i;
   logic [ADDR_W-1:0]   wb_adr_i;
   logic [3:0]          wb_sel_i;
   logic [31:0]         wb_dat_i;
   logic [31:0]         wb_dat_o;
   logic                wb_ack_o;
   logic [PINS-1:0]     pwm_out;
   logic [PINS-1:0]     pwm_oe_n;
   int                  n_mismatch = 0;
   int                  checked = 0;
   int                  cyc_cnt = 0;
   int                  win_start = 1000000;
   int                  nh [8];
   logic [31:0]         rd;
   logic [5:0]          nval [8] = '{6'h00, 6'h01, 6'h3F, 6'h20, 6'h15, 6'h2A, 6'h07, 6'h38};
   // Row r is timed in slots 2r+1 and 2r+2; rows 1, 2, 3, 5 and 7 meet an owned slot there, rows 4 and 6 do not.
   row_t                rows [8] = '{'{8'h03, 6'h00}, '{8'h03, 6'h20}, '{8'h07, 6'h10},
                                     '{8'h02, 6'h04}, '{8'h04, 6'h02}, '{8'h06, 6'h08},
                                     '{8'h01, 6'h01}, '{8'h09, 6'h3F}};

   pwm_unit u_dut (
      .ref_clk  (ref_clk),
      .rst      (rst),
      .wb_cyc_i (wb_cyc_i),
      .wb_stb_i (wb_stb_i),
      .wb_we_i  (wb_we_i),
      .wb_adr_i (wb_adr_i),
      .wb_sel_i (wb_sel_i),
      .wb_dat_i (wb_dat_i),
      .wb_dat_o (wb_dat_o),
      .wb_ack_o (wb_ack_o),
      .pwm_out  (pwm_out),
      .pwm_oe_n (pwm_oe_n)
   );

   initial begin
      ref_clk = 1'b0;
      forever #25 ref_clk = ~ref_clk;
   end

   task automatic end_of_test();
      $display("comparisons %0d mismatches %0d", checked, n_mismatch);
      if (n_mismatch == 0 && checked > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask

   // The narrow window spans exactly one period, so any phase gives the exact high count.
   always @(posedge ref_clk) begin
      cyc_cnt++;
      if (cyc_cnt >= win_start && cyc_cnt < win_start + 20480) begin
         for (int i = 0; i < 8; i++) begin
            nh[i] += int'(pwm_out[i+1]);
         end
      end
      // The whole run needs about 50000 cycles; the ceiling leaves ample margin.
      if (cyc_cnt == 80000) begin
         n_mismatch++;
         end_of_test();
      end
   end

   task automatic wb(input logic we, input logic [7:0] adr, input logic [31:0] dat,
                     input logic [3:0] sel);
      @(posedge ref_clk);
      wb_cyc_i <= 1'b1;
      wb_stb_i <= 1'b1;
      wb_we_i  <= we;
      wb_adr_i <= adr;
      wb_dat_i <= dat;
      wb_sel_i <= sel;
      do begin
         @(posedge ref_clk);
      end while (wb_ack_o !== 1'b1);
      rd = wb_dat_o;
      wb_cyc_i <= 1'b0;
      wb_stb_i <= 1'b0;
      wb_we_i  <= 1'b0;
   endtask

   function automatic int stretch(input int m, input logic [5:0] lo);
      return (lo[0] && m == 32) || (lo[1] && m % 32 == 16) || (lo[2] && m % 16 == 8)
          || (lo[3] && m % 8 == 4) || (lo[4] && m % 4 == 2) || (lo[5] && m % 2 == 1);
   endfunction

   // Finds the next slot start, times its high run, then reads which slot it was.
   task automatic measure(input logic [7:0] hi, input logic [5:0] lo);
      int n;
      int slot;
      n = 0;
      // A low write can raise a late partial run in the current slot; waiting past the
      // widest run used keeps the timing on a whole slot.
      repeat (200) @(posedge ref_clk);
      while (pwm_out[0] !== 1'b0 && n < 3000) begin
         @(posedge ref_clk);
         n++;
      end
      while (pwm_out[0] !== 1'b1 && n < 6000) begin
         @(posedge ref_clk);
         n++;
      end
      n = 0;
      while (pwm_out[0] === 1'b1 && n < 3000) begin
         n++;
         @(posedge ref_clk);
      end
      wb(1'b0, OFS_STATUS, 32'h0, 4'h1);
      slot = int'(rd[5:0]);
      `CHK("wide high run", (int'(hi) + stretch(slot, lo)) * STEP_CYCLES, n)
   endtask

   initial begin
      rst = 1'b1;
      wb_cyc_i = 1'b0;
      wb_stb_i = 1'b0;
      wb_we_i = 1'b0;
      wb_adr_i = 8'h00;
      wb_sel_i = 4'h0;
      wb_dat_i = 32'h0;
      for (int i = 0; i < 8; i++) nh[i] = 0;
      repeat (20) @(posedge ref_clk);
      rst <= 1'b0;
      @(posedge ref_clk);
      `CHK("oe after reset", 9'h1FF, pwm_oe_n)
      `CHK("ack after reset", 1'b0, wb_ack_o)
      $display("test reset done");

      for (int i = 0; i < 8; i++) wb(1'b1, OFS_NARROW_BASE + 8'(4 * i), 32'(nval[i]), 4'h1);
      win_start = cyc_cnt + 21200;
      `CHK("oe before select", 9'h1FF, pwm_oe_n)
      wb(1'b1, OFS_OUT_CTRL1, 32'h02, 4'h1);
      repeat (3) @(posedge ref_clk);
      `CHK("oe wide only", 9'h1FE, pwm_oe_n)
      wb(1'b1, OFS_OUT_CTRL1, 32'hFE, 4'h1);
      wb(1'b1, OFS_OUT_CTRL2, 32'h03, 4'h1);
      repeat (3) @(posedge ref_clk);
      `CHK("oe all", 9'h000, pwm_oe_n)
      wb(1'b0, OFS_NARROW_BASE + 8'h14, 32'h0, 4'h1);
      `CHK("narrow readback", 32'(nval[5]), rd)
      wb(1'b0, 8'hFC, 32'h0, 4'h1);
      `CHK("unmapped read", 32'h0, rd)
      wb(1'b1, OFS_WIDE_HIGH, 32'h5A, 4'h1);
      wb(1'b1, OFS_WIDE_HIGH, 32'hA5, 4'h0);
      wb(1'b0, OFS_WIDE_HIGH, 32'h0, 4'h1);
      `CHK("lane masked write", 32'h5A, rd)
      $display("test registers done");

      foreach (rows[r]) begin
         wb(1'b1, OFS_WIDE_HIGH, 32'(rows[r].hi), 4'h1);
         wb(1'b1, OFS_WIDE_LOW, 32'(rows[r].lo), 4'h1);
         measure(rows[r].hi, rows[r].lo);
         measure(rows[r].hi, rows[r].lo);
         $display("test wide row %0d done", r);
      end

      // A high byte alone must not reach the modulator until the low bits follow.
      wb(1'b1, OFS_WIDE_HIGH, 32'h0C, 4'h1);
      measure(rows[7].hi, rows[7].lo);
      wb(1'b1, OFS_WIDE_LOW, 32'h00, 4'h1);
      measure(8'h0C, 6'h00);
      $display("test wide transfer done");

      while (cyc_cnt < win_start + 20490) @(posedge ref_clk);
      for (int i = 0; i < 8; i++) begin
         `CHK("narrow high count", int'(nval[i]) * NARROW_SEG_STEPS * STEP_CYCLES, nh[i])
      end
      $display("test narrow done");
      end_of_test();
   end
endmodule
